// file: logic/ppdc_port.sv
/*
  Driver control for one port of general-purpose pins plus the PWM pins, with APB registers.
  Assumes synchronous pin levels, straps stable at reset release, APB master on pclk.
*/
`include "ppdc_map.svh"
module ppdc_port
  import ppdc_pkg::*;
#(
  parameter int NPIN = 8,
  parameter int NPWM = 2,
  parameter int PROG_CLK_PIN = 7,
  parameter int PROG_DAT_PIN = 6,
  parameter bit QUASI_ONLY = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PPDC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_level_select,
  input wire logic default_mode_select,
  input wire logic serial_flash_program_mode,
  input wire logic [NPIN-1:0] pin_level,
  output logic [NPIN-1:0] very_weak_pu,
  output logic [NPIN-1:0] weak_pu,
  output logic [NPIN-1:0] strong_pu,
  output logic [NPIN-1:0] pull_down,
  output logic [NPIN-1:0] pin_rx,
  input wire logic [NPWM-1:0] pwm_out,
  output logic [NPWM-1:0] pwm_pin_o,
  output logic [NPWM-1:0] pwm_pin_oe
);
  localparam int CW = 2;
  logic [NPIN-1:0] latch_ff, nxt_latch;
  logic [NPIN-1:0] mhi_ff, nxt_mhi;
  logic [NPIN-1:0] mlo_ff, nxt_mlo;
  logic thresh_ff;
  logic init_ff;
  logic [31:0] prdata_ff;
  logic [NPIN-1:0] vw_ff, wk_ff, st_ff, pd_ff, rx_ff;
  logic [NPWM-1:0] pwm_o_ff, pwm_oe_ff;
  logic [CW-1:0] cnt_ff [NPIN];
  logic [NPIN-1:0] smt_rx, ttl_rx;
  ppdc_drv_t drv [NPIN];

  wire wr_acc = psel && penable && pwrite;
  wire rd_acc = psel && penable && !pwrite;
  wire hit_latch = paddr == `PPDC_OFF_LATCH;
  wire hit_mhi = paddr == `PPDC_OFF_MODE_HI;
  wire hit_mlo = paddr == `PPDC_OFF_MODE_LO;
  wire hit_thr = paddr == `PPDC_OFF_THRESH;
  wire hit_pin = paddr == `PPDC_OFF_PIN;
  wire hit_stat = paddr == `PPDC_OFF_STAT;
  wire hit_any = hit_latch | hit_mhi | hit_mlo | hit_thr | hit_pin | hit_stat;
  wire [31:0] rd_mux =
    hit_latch ? 32'(latch_ff) :
    hit_mhi ? 32'(mhi_ff) :
    hit_mlo ? 32'(mlo_ff) :
    hit_thr ? 32'(thresh_ff) :
    hit_pin ? 32'(rx_ff) :
    hit_stat ? 32'({st_ff, serial_flash_program_mode}) : 32'h0000_0000;

  // Straps are captured at the first clock after reset release, not by the async reset.
  wire [NPIN-1:0] rst_latch = {NPIN{reset_level_select}};
  wire [NPIN-1:0] rst_mode = (default_mode_select || QUASI_ONLY) ? '0 : '1;

  assign nxt_latch = init_ff ? rst_latch :
                     (wr_acc && hit_latch) ? pwdata[NPIN-1:0] : latch_ff;
  assign nxt_mhi = QUASI_ONLY ? '0 : init_ff ? rst_mode :
                   (wr_acc && hit_mhi) ? pwdata[NPIN-1:0] : mhi_ff;
  assign nxt_mlo = QUASI_ONLY ? '0 : init_ff ? rst_mode :
                   (wr_acc && hit_mlo) ? pwdata[NPIN-1:0] : mlo_ff;
  assign smt_rx = pin_level;
  assign ttl_rx = pin_level;

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      wire ppdc_mode_t mode = ppdc_mode_t'({mhi_ff[g], mlo_ff[g]});
      wire rise = nxt_latch[g] && !latch_ff[g] && !init_ff;
      wire pulse_on = cnt_ff[g] != '0;
      // The two programming pins must look quasi-high for the whole reset.
      localparam bit PROG_RST = (g == PROG_CLK_PIN) || (g == PROG_DAT_PIN);
      wire prog_pin = PROG_RST;
      wire [CW-1:0] nxt_cnt = (rise && mode == PPDC_QUASI) ? CW'(`PPDC_STRONG_CYC) :
                              pulse_on ? cnt_ff[g] - CW'(1) : '0;
      always_comb begin
        drv[g] = '0;
        if (init_ff && prog_pin) begin
          drv[g].very_weak_pu = 1'b1;
          drv[g].weak_pu = pin_level[g];
        end else begin
          case (mode)
            PPDC_QUASI: begin
              drv[g].very_weak_pu = latch_ff[g];
              drv[g].weak_pu = latch_ff[g] && pin_level[g];
              drv[g].strong_pu = latch_ff[g] && pulse_on;
              drv[g].pull_down = !latch_ff[g];
            end
            PPDC_PUSH: begin
              drv[g].strong_pu = latch_ff[g];
              drv[g].pull_down = !latch_ff[g];
            end
            PPDC_OPEN: drv[g].pull_down = !latch_ff[g];
            PPDC_INPUT: drv[g] = '0;
            default: drv[g] = '0;
          endcase
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_ff[g] <= '0;
          vw_ff[g] <= PROG_RST;
          wk_ff[g] <= 1'b0;
          st_ff[g] <= 1'b0;
          pd_ff[g] <= 1'b0;
          rx_ff[g] <= 1'b0;
        end else begin
          cnt_ff[g] <= nxt_cnt;
          vw_ff[g] <= drv[g].very_weak_pu;
          wk_ff[g] <= drv[g].weak_pu;
          st_ff[g] <= drv[g].strong_pu;
          pd_ff[g] <= drv[g].pull_down;
          rx_ff[g] <= thresh_ff ? smt_rx[g] : ttl_rx[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_ff <= 1'b1;
      latch_ff <= '0;
      mhi_ff <= '0;
      mlo_ff <= '0;
      thresh_ff <= 1'b1;
      prdata_ff <= 32'h0000_0000;
      pwm_o_ff <= '0;
      pwm_oe_ff <= '0;
    end else begin
      init_ff <= 1'b0;
      latch_ff <= nxt_latch;
      mhi_ff <= nxt_mhi;
      mlo_ff <= nxt_mlo;
      if (wr_acc && hit_thr) begin
        thresh_ff <= pwdata[0];
      end
      prdata_ff <= (psel && !penable && !pwrite) ? rd_mux : prdata_ff;
      pwm_o_ff <= pwm_out;
      pwm_oe_ff <= serial_flash_program_mode ? '0 : '1;
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign very_weak_pu = vw_ff;
  assign weak_pu = wk_ff;
  assign strong_pu = st_ff;
  assign pull_down = pd_ff;
  assign pin_rx = rx_ff;
  assign pwm_pin_o = pwm_o_ff;
  assign pwm_pin_oe = pwm_oe_ff;

  wire unused_ok = rd_acc | hit_any;

  a_quasi_low_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (!init_ff && mhi_ff == 0 && mlo_ff == 0 && !latch_ff[0]) |=> pull_down[0])
    else $error("quasi low latch not driven low");
  a_strong_two_cyc: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(latch_ff[0]) && !mhi_ff[0] && !mlo_ff[0] && !$past(init_ff) && !init_ff)
    |=> strong_pu[0] ##1 (strong_pu[0] || !latch_ff[0]) ##1 !strong_pu[0])
    else $error("strong pull-up pulse length wrong");
  a_open_no_pull: assert property (@(posedge pclk) disable iff (!presetn)
    (mhi_ff[1] && mlo_ff[1] && !init_ff) |=> !very_weak_pu[1] && !weak_pu[1] && !strong_pu[1])
    else $error("pull-up active in open drain");
  a_push_high: assert property (@(posedge pclk) disable iff (!presetn)
    (!mhi_ff[2] && mlo_ff[2] && latch_ff[2] && !init_ff) |=> strong_pu[2])
    else $error("push-pull high not driven");
  a_weak_follow: assert property (@(posedge pclk) disable iff (!presetn)
    (!init_ff && !mhi_ff[3] && !mlo_ff[3] && latch_ff[3] && !pin_level[3]) |=> !weak_pu[3])
    else $error("weak pull-up on with pin low");
  a_vweak_follow: assert property (@(posedge pclk) disable iff (!presetn)
    (!init_ff && !mhi_ff[4] && !mlo_ff[4]) |=> very_weak_pu[4] == $past(latch_ff[4]))
    else $error("very weak pull-up mismatch");
  a_pwm_tristate: assert property (@(posedge pclk) disable iff (!presetn)
    serial_flash_program_mode |=> pwm_pin_oe == '0)
    else $error("pwm pin driven in programming mode");
  a_input_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (mhi_ff[5] && !mlo_ff[5] && !init_ff) |=> !pull_down[5] && !very_weak_pu[5])
    else $error("input-only pin driven");
  a_reset_level: assert property (@(posedge pclk) disable iff (!presetn)
    init_ff |=> latch_ff == {NPIN{$past(reset_level_select)}})
    else $error("latch reset level wrong");

  // Programming pins stay quasi-high through reset and the strap load cycle.
  a_prog_init_high: assert property (@(posedge pclk) disable iff (!presetn)
    init_ff |-> very_weak_pu[PROG_CLK_PIN] && very_weak_pu[PROG_DAT_PIN])
    else $error("programming pins not quasi-high after reset");
  a_prog_init_next: assert property (@(posedge pclk) disable iff (!presetn)
    init_ff |=> very_weak_pu[PROG_CLK_PIN] && very_weak_pu[PROG_DAT_PIN])
    else $error("programming pins not quasi-high in load cycle");
  a_prog_weak_follow: assert property (@(posedge pclk) disable iff (!presetn)
    init_ff |=> weak_pu[PROG_CLK_PIN] == $past(pin_level[PROG_CLK_PIN]))
    else $error("programming clock weak pull-up wrong");

  // Mode straps land in the mode bits at the load cycle.
  a_mode_reset: assert property (@(posedge pclk) disable iff (!presetn)
    (init_ff && !QUASI_ONLY) |=> mhi_ff == {NPIN{!$past(default_mode_select)}} &&
      mlo_ff == {NPIN{!$past(default_mode_select)}})
    else $error("mode bits reset value wrong");

  // Register writes take effect on the next edge and are held otherwise.
  a_latch_take: assert property (@(posedge pclk) disable iff (!presetn)
    (!init_ff && psel && penable && pwrite && paddr == `PPDC_OFF_LATCH)
    |=> latch_ff == $past(pwdata[NPIN-1:0]))
    else $error("latch write lost");
  a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!init_ff && !(psel && penable && pwrite && paddr == `PPDC_OFF_LATCH))
    |=> $stable(latch_ff))
    else $error("latch changed without write");
  a_mode_hi_take: assert property (@(posedge pclk) disable iff (!presetn)
    (!init_ff && !QUASI_ONLY && psel && penable && pwrite && paddr == `PPDC_OFF_MODE_HI)
    |=> mhi_ff == $past(pwdata[NPIN-1:0]))
    else $error("mode high write lost");
  a_mode_lo_take: assert property (@(posedge pclk) disable iff (!presetn)
    (!init_ff && !QUASI_ONLY && psel && penable && pwrite && paddr == `PPDC_OFF_MODE_LO)
    |=> mlo_ff == $past(pwdata[NPIN-1:0]))
    else $error("mode low write lost");
  a_thresh_take: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && paddr == `PPDC_OFF_THRESH) |=> thresh_ff == $past(pwdata[0]))
    else $error("threshold write lost");

  // Driver outputs per mode, one cycle after the cause.
  a_quasi_low_nopu: assert property (@(posedge pclk) disable iff (!presetn)
    (!init_ff && !mhi_ff[0] && !mlo_ff[0] && !latch_ff[0])
    |=> !very_weak_pu[0] && !weak_pu[0] && !strong_pu[0])
    else $error("pull-up on with quasi latch low");
  a_quasi_low_prog: assert property (@(posedge pclk) disable iff (!presetn)
    (!init_ff && !mhi_ff[6] && !mlo_ff[6] && !latch_ff[6]) |=> pull_down[6])
    else $error("quasi programming pin not driven low");
  a_quasi_weak_on: assert property (@(posedge pclk) disable iff (!presetn)
    (!init_ff && !mhi_ff[3] && !mlo_ff[3] && latch_ff[3] && pin_level[3]) |=> weak_pu[3])
    else $error("weak pull-up off with latch and pin high");
  a_open_pd: assert property (@(posedge pclk) disable iff (!presetn)
    (!init_ff && mhi_ff[1] && mlo_ff[1]) |=> pull_down[1] == !$past(latch_ff[1]))
    else $error("open drain pull-down wrong");
  a_open_pd_prog: assert property (@(posedge pclk) disable iff (!presetn)
    (!init_ff && mhi_ff[6] && mlo_ff[6]) |=> !strong_pu[6] && !very_weak_pu[6])
    else $error("open drain programming pin pulled up");
  a_no_strong_hi: assert property (@(posedge pclk) disable iff (!presetn)
    (!init_ff && mhi_ff[1]) |=> !strong_pu[1])
    else $error("strong pull-up in input or open drain");
  a_push_low_pd: assert property (@(posedge pclk) disable iff (!presetn)
    (!init_ff && !mhi_ff[2] && mlo_ff[2] && !latch_ff[2]) |=> pull_down[2] && !strong_pu[2])
    else $error("push-pull low not driven");
  a_push_no_weak: assert property (@(posedge pclk) disable iff (!presetn)
    (!init_ff && !mhi_ff[2] && mlo_ff[2]) |=> !very_weak_pu[2] && !weak_pu[2])
    else $error("weak pull-up in push-pull");
  a_push_high_prog: assert property (@(posedge pclk) disable iff (!presetn)
    (!init_ff && !mhi_ff[7] && mlo_ff[7] && latch_ff[7]) |=> strong_pu[7])
    else $error("push-pull programming pin not high");
  a_input_no_pu: assert property (@(posedge pclk) disable iff (!presetn)
    (!init_ff && mhi_ff[5] && !mlo_ff[5]) |=> !weak_pu[5] && !strong_pu[5])
    else $error("input-only pin pulled up");
  a_input_no_pd: assert property (@(posedge pclk) disable iff (!presetn)
    (!init_ff && mhi_ff[4] && !mlo_ff[4]) |=> !pull_down[4])
    else $error("input-only pin pulled down");
  a_nonquasi_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (!init_ff && (mhi_ff[3] || mlo_ff[3])) |=> !very_weak_pu[3] && !weak_pu[3])
    else $error("quasi pull-up outside quasi mode");

  // Receiver and PWM pin paths.
  a_rx_follow: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> pin_rx == $past(pin_level))
    else $error("received level wrong");
  a_pwm_pass: assert property (@(posedge pclk) disable iff (!presetn)
    !serial_flash_program_mode |=> pwm_pin_oe == '1 && pwm_pin_o == $past(pwm_out))
    else $error("pwm pin not driven outside programming mode");

  c_strong_pulse: cover property (@(posedge pclk) disable iff (!presetn) $rose(strong_pu[0]));
  c_prog_mode: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(serial_flash_program_mode));
  c_open_low: cover property (@(posedge pclk) disable iff (!presetn)
    mhi_ff[1] && mlo_ff[1] && pull_down[1]);
  c_push_high: cover property (@(posedge pclk) disable iff (!presetn)
    !mhi_ff[2] && mlo_ff[2] && strong_pu[2]);
  c_open_reset: cover property (@(posedge pclk) disable iff (!presetn)
    init_ff && !default_mode_select);
endmodule // ppdc_port

// file: logic/ppdc_map.svh
/*
  Constants for the port pin driver control block: register offsets, timing, address width.
  Assumes an APB master on pclk at 100 MHz and an asynchronous active-low reset.
*/
`ifndef PPDC_MAP_SVH
`define PPDC_MAP_SVH
`define PPDC_OFF_LATCH 12'h000
`define PPDC_OFF_MODE_HI 12'h004
`define PPDC_OFF_MODE_LO 12'h008
`define PPDC_OFF_THRESH 12'h00c
`define PPDC_OFF_PIN 12'h010
`define PPDC_OFF_STAT 12'h014
`define PPDC_STRONG_NS 20
`define PPDC_CLK_NS 10
`define PPDC_STRONG_CYC (`PPDC_STRONG_NS / `PPDC_CLK_NS)
`define PPDC_ADDR_W 12
`endif

// file: logic/ppdc_pkg.sv
/*
  Types for the port pin driver control block.
  Assumes ppdc_map.svh is compiled alongside.
*/
package ppdc_pkg;
  typedef enum logic [1:0] {
    PPDC_QUASI = 2'b00,
    PPDC_PUSH = 2'b01,
    PPDC_INPUT = 2'b10,
    PPDC_OPEN = 2'b11
  } ppdc_mode_t;
  typedef struct packed {
    logic very_weak_pu;
    logic weak_pu;
    logic strong_pu;
    logic pull_down;
  } ppdc_drv_t;
endpackage

// file: dv/ppdc_ext_ckt.sv
/*
  Model of the board circuitry on the port pins: a resistor pull-up on every pin.
  Assumes the bench may hold selected pins low to act as an external driver.
*/
module ppdc_ext_ckt #(
  parameter int NPIN = 8
) (
  input wire logic [NPIN-1:0] pull_down,
  input wire logic [NPIN-1:0] ext_low,
  output logic [NPIN-1:0] pin_level
);
  timeunit 1ns;
  timeprecision 100ps;
  // The resistor lifts any pin that nobody pulls low.
  assign pin_level = ~pull_down & ~ext_low;
endmodule // ppdc_ext_ckt

// file: dv/tb.sv
/*
  Self-checking bench for ppdc_port: APB master, strap and pin stimulus, behavioural model.
  Assumes ppdc_pkg, ppdc_map.svh and ppdc_ext_ckt are compiled first.
*/
`include "ppdc_map.svh"
module tb
  import ppdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rl, dm, prog;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0] pin, vw, wk, sp, pd, rx, ext, l;
  logic [1:0] pwm, pwm_o, pwm_oe;
  int errors, tests_run, cyc, n, seed;
  wire [31:0] drv = {vw, wk, sp, pd};
  ppdc_port ppdc_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_level_select(rl), .default_mode_select(dm),
    .serial_flash_program_mode(prog), .pin_level(pin), .very_weak_pu(vw), .weak_pu(wk),
    .strong_pu(sp), .pull_down(pd), .pin_rx(rx), .pwm_out(pwm), .pwm_pin_o(pwm_o),
    .pwm_pin_oe(pwm_oe));
  ppdc_ext_ckt ppdc_ext_ckt_inst (.pull_down(pd), .ext_low(ext), .pin_level(pin));
  always #5 pclk = ~pclk;
  // Steady driver state expected for a mode, latch value and external low mask.
  function automatic logic [31:0] expv(ppdc_mode_t m, logic [7:0] lt, logic [7:0] e);
    logic [7:0] p;
    p = ~e & ((m == PPDC_INPUT) ? 8'hff : lt);
    return {(m == PPDC_QUASI) ? lt : 8'h00, (m == PPDC_QUASI) ? (lt & p) : 8'h00,
      (m == PPDC_PUSH) ? lt : 8'h00, (m != PPDC_INPUT) ? ~lt : 8'h00};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle();
    repeat (4) @(posedge pclk);
    #1;
  endtask
  task automatic wrap_up();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic do_reset(input logic lvl, input logic dmode);
    rl <= lvl;
    dm <= dmode;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk("prog_pins_rst", 32'hc0, {24'h0, vw});
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    settle();
  endtask
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    rl = 1; dm = 1; prog = 0; ext = 0; pwm = 0; errors = 0; tests_run = 0; cyc = 0;
    seed = 27857;
    do_reset(1'b1, 1'b1);
    chk("drv_reset", expv(PPDC_QUASI, 8'hff, 8'h00), drv);
    apb(1'b0, `PPDC_OFF_THRESH, 32'h0);
    chk("thresh", 32'h1, r);
    chk("pslverr", 32'h0, {31'h0, pslverr});
    ext <= $random(seed);
    settle();
    chk("drv_ext", expv(PPDC_QUASI, 8'hff, ext), drv);
    chk("rx", {24'h0, ~ext}, {24'h0, rx});
    ext <= 8'h00;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `PPDC_OFF_LATCH, 32'h0);
      apb(1'b1, `PPDC_OFF_MODE_HI, {24'h0, {8{i[1]}}});
      apb(1'b1, `PPDC_OFF_MODE_LO, {24'h0, {8{i[0]}}});
      settle();
      chk("drv_zero", expv(ppdc_mode_t'(i), 8'h00, 8'h00), drv);
      apb(1'b1, `PPDC_OFF_LATCH, 32'hff);
      n = 0;
      repeat (6) begin
        @(posedge pclk);
        #1;
        if (sp === 8'hff) n++;
      end
      chk("pulse", (i == 0) ? 2 : (i == 1) ? 6 : 0, n);
      l = $random(seed);
      apb(1'b1, `PPDC_OFF_LATCH, {24'h0, l});
      settle();
      chk("drv_rand", expv(ppdc_mode_t'(i), l, 8'h00), drv);
    end
    pwm <= $random(seed);
    prog <= 1'b1;
    settle();
    chk("pwm_oe", 32'h0, {30'h0, pwm_oe});
    chk("pwm_o", {30'h0, pwm}, {30'h0, pwm_o});
    prog <= 1'b0;
    settle();
    chk("pwm_oe_run", 32'h3, {30'h0, pwm_oe});
    apb(1'b0, 12'hff0, 32'h0);
    chk("unmapped", 32'h0, r);
    do_reset(1'b0, 1'b0);
    chk("drv_low", expv(PPDC_OPEN, 8'h00, 8'h00), drv);
    apb(1'b0, `PPDC_OFF_MODE_HI, 32'h0);
    chk("mode_hi", 32'hff, r);
    wrap_up();
  end
endmodule // tb
